//--- hdl/flash_seq_regs.svh
// Summary of operation
// - Wrap setting: opcode, 24 or 32 dummy bits, then one captured config byte.
// - Only bits six to four of the wrap byte matter; others ignored.
// - Wrap length field 00/01/10/11 gives 8/16/32/64-byte window in page.
// - Wrap disable bit set to one at power-on and any reset.
// - Stored wrap setting applies to all later quad reads in any page.
// - Four-byte address mode needs 32 dummy bits; wrap setting is standard mode only.
// - Four-lane mode keeps wrap length; read-parameter command may change it.
// - Page program accepted only while write enable latch is one.
// - Only low eight address bits advance; overflow wraps and overwrites buffered bytes.
// - Program runs only if select rises right after a whole byte.
// - Self-timed program cycle shows busy one, then clears it when done.
// - Write enable latch clears when the program cycle finishes.
// - Program to a protected page is skipped.
// - Four-byte program variant always takes a 32-bit address.
// - Four-byte program variant only recognised in standard mode.
// - Quad program needs quad enable and latch; data arrives on four lanes.
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
`define OP_SET_WRAP 8'h77
`define OP_PP 8'h02
`define OP_PP4 8'h12
`define OP_QPP 8'h32
`define WRAP_DIS_POS 4
`define WRAP_LEN_LO 5
`define WRAP_LEN_HI 6
`define WRAP_RESET 3'h1
`define ADDR_BITS_3B 6'd24
`define ADDR_BITS_4B 6'd32
`define BYTE_BITS 6'd8
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 20000
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_WORDS 4
`endif

//--- hdl/flash_seq_pkg.sv
package flash_seq_pkg;
   // Gray steps along opcode, address, data, flush, program, idle
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_OPC = 4'h1,
      ST_ADDR = 4'h3,
      ST_DATA = 4'h2,
      ST_FLUSH = 4'h6,
      ST_PROG = 4'h4,
      ST_DUMMY = 4'h5,
      ST_WRAP = 4'h7,
      ST_SKIP = 4'h8
   } seq_state_t;
endpackage

//--- hdl/sync_fifo.sv
`timescale 1ns/100ps
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_state_t;
   fifo_state_t r, n;
   logic push, pop;

   // Honest flags straight from the fill count
   assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (r.cnt != '0);
   assign out_data_o = r.mem[r.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Pointers wrap explicitly so depths need not be powers of two
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wp] = in_data_i;
         n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
      end
      n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_fifo_fills;
      @(posedge clk_i) disable iff (!rst_b_i)
      (push && !pop && r.cnt == (AW+1)'(DEPTH - 1)) |=> !in_ready_o;
   endproperty
   a_fifo_fills: assert property (p_fifo_fills) else $error("fifo did not report full");
endmodule

//--- hdl/flash_seq.sv
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module flash_seq (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic cs_b_i,
   input wire logic sclk_i,
   input wire logic [3:0] io_i,
   input wire logic four_byte_mode_i,
   input wire logic four_lane_command_mode_i,
   input wire logic quad_io_enable_i,
   input wire logic write_enable_set_i,
   input wire logic sw_reset_i,
   input wire logic rd_param_wr_i,
   input wire logic [1:0] rd_param_len_i,
   input wire logic page_protected_i,
   input wire logic [31:0] rd_addr_i,
   input wire logic mem_ready_i,
   output logic busy_o,
   output logic write_enable_latch_o,
   output logic wrap_disable_bit_o,
   output logic [1:0] wrap_length_field_o,
   output logic [6:0] wrap_bytes_o,
   output logic [31:0] rd_next_o,
   output logic [23:0] prot_page_o,
   output logic mem_valid_o,
   output logic [31:0] mem_addr_o,
   output logic [7:0] mem_clear_mask_o
);
   localparam int PROG_CYC = `PROG_CYCLES;
   typedef struct packed {
      logic cs_m;
      logic cs_s;
      logic cs_d;
      logic sck_m;
      logic sck_s;
      logic sck_d;
      logic [3:0] io_m;
      logic [3:0] io_s;
      flash_seq_pkg::seq_state_t st;
      logic [31:0] sh;
      logic [5:0] cnt;
      logic a32;
      logic quad;
      logic got;
      logic [23:0] page;
      logic [7:0] ptr;
      logic [255:0][7:0] pbuf;
      logic [255:0] vld;
      logic [8:0] idx;
      logic [2:0] wrap;
      logic write_enable_latch;
      logic busy;
      logic [15:0] tmr;
   } seq_reg_t;
   seq_reg_t r, n;
   logic sck_rise, cs_start, cs_stop, lane4;
   logic [31:0] shifted;
   logic [5:0] ncnt, alen;
   logic fifo_in_valid, fifo_in_ready;
   logic [39:0] fifo_out;
   logic [7:0] wmask;

   ////////////////////////////////////////////////////////////////////////
   // Link edges, taken only from the second synchroniser stage onward
   assign sck_rise = r.sck_s & ~r.sck_d;
   assign cs_start = ~r.cs_s & r.cs_d;
   assign cs_stop = r.cs_s & ~r.cs_d;
   assign lane4 = (r.st == flash_seq_pkg::ST_DATA) ? r.quad : four_lane_command_mode_i;
   assign shifted = lane4 ? {r.sh[27:0], r.io_s} : {r.sh[30:0], r.io_s[0]};
   assign ncnt = r.cnt + (lane4 ? 6'd4 : 6'd1);
   assign alen = r.a32 ? `ADDR_BITS_4B : `ADDR_BITS_3B;
   assign fifo_in_valid = (r.st == flash_seq_pkg::ST_FLUSH) && !r.idx[8] && r.vld[r.idx[7:0]];

   // Command sequencer
   always_comb begin
      n = r;
      n.cs_m = cs_b_i;
      n.cs_s = r.cs_m;
      n.cs_d = r.cs_s;
      n.sck_m = sclk_i;
      n.sck_s = r.sck_m;
      n.sck_d = r.sck_s;
      n.io_m = io_i;
      n.io_s = r.io_m;
      case (r.st)
         flash_seq_pkg::ST_IDLE: begin
            // Frames during the program cycle belong to status logic elsewhere
            if (cs_start && !r.busy) begin
               n.st = flash_seq_pkg::ST_OPC;
               n.cnt = '0;
               n.sh = '0;
            end
         end
         flash_seq_pkg::ST_OPC: begin
            if (cs_stop) begin
               n.st = flash_seq_pkg::ST_IDLE;
            end else if (sck_rise) begin
               n.sh = shifted;
               n.cnt = ncnt;
               if (ncnt == `BYTE_BITS) begin
                  n.cnt = '0;
                  n.sh = '0;
                  n.st = flash_seq_pkg::ST_SKIP;
                  n.a32 = four_byte_mode_i;
                  n.quad = four_lane_command_mode_i;
                  n.got = 1'b0;
                  n.vld = '0;
                  case (shifted[7:0])
                     `OP_SET_WRAP: begin
                        if (!four_lane_command_mode_i) begin
                           n.st = flash_seq_pkg::ST_DUMMY;
                        end
                     end
                     `OP_PP: begin
                        if (r.write_enable_latch) begin
                           n.st = flash_seq_pkg::ST_ADDR;
                        end
                     end
                     `OP_PP4: begin
                        if (r.write_enable_latch && !four_lane_command_mode_i) begin
                           n.st = flash_seq_pkg::ST_ADDR;
                           n.a32 = 1'b1;
                        end
                     end
                     `OP_QPP: begin
                        if (r.write_enable_latch && quad_io_enable_i && !four_lane_command_mode_i) begin
                           n.st = flash_seq_pkg::ST_ADDR;
                           n.quad = 1'b1;
                        end
                     end
                     default: n.st = flash_seq_pkg::ST_SKIP;
                  endcase
               end
            end
         end
         flash_seq_pkg::ST_DUMMY: begin
            if (cs_stop) begin
               n.st = flash_seq_pkg::ST_IDLE;
            end else if (sck_rise) begin
               n.cnt = ncnt;
               if (ncnt == alen) begin
                  n.cnt = '0;
                  n.st = flash_seq_pkg::ST_WRAP;
               end
            end
         end
         flash_seq_pkg::ST_WRAP: begin
            if (cs_stop) begin
               n.st = flash_seq_pkg::ST_IDLE;
            end else if (sck_rise) begin
               n.sh = shifted;
               n.cnt = ncnt;
               if (ncnt == `BYTE_BITS) begin
                  // Top bit and low nibble are dropped here
                  n.wrap = shifted[`WRAP_LEN_HI:`WRAP_DIS_POS];
                  n.st = flash_seq_pkg::ST_SKIP;
               end
            end
         end
         flash_seq_pkg::ST_ADDR: begin
            if (cs_stop) begin
               n.st = flash_seq_pkg::ST_IDLE;
            end else if (sck_rise) begin
               n.sh = shifted;
               n.cnt = ncnt;
               if (ncnt == alen) begin
                  n.cnt = '0;
                  n.page = r.a32 ? shifted[31:8] : {8'h00, shifted[23:8]};
                  n.ptr = shifted[7:0];
                  n.st = flash_seq_pkg::ST_DATA;
               end
            end
         end
         flash_seq_pkg::ST_DATA: begin
            if (cs_stop) begin
               // Only a whole last byte arms the cycle
               if (r.cnt == '0 && r.got && !page_protected_i) begin
                  n.st = flash_seq_pkg::ST_FLUSH;
                  n.busy = 1'b1;
                  n.idx = '0;
               end else begin
                  n.st = flash_seq_pkg::ST_IDLE;
               end
            end else if (sck_rise) begin
               n.sh = shifted;
               n.cnt = ncnt;
               if (ncnt == `BYTE_BITS) begin
                  n.cnt = '0;
                  n.got = 1'b1;
                  // Later bytes to the same slot replace earlier ones
                  n.pbuf[r.ptr] = shifted[7:0];
                  n.vld[r.ptr] = 1'b1;
                  n.ptr = r.ptr + 8'h01;
               end
            end
         end
         flash_seq_pkg::ST_FLUSH: begin
            // Stalls while the memory port is backed up
            if (r.idx[8]) begin
               n.st = flash_seq_pkg::ST_PROG;
               n.tmr = '0;
            end else if (!fifo_in_valid || fifo_in_ready) begin
               n.idx = r.idx + 9'h001;
            end
         end
         flash_seq_pkg::ST_PROG: begin
            if (r.tmr != 16'(PROG_CYC)) begin
               n.tmr = r.tmr + 16'h0001;
            end else if (!mem_valid_o) begin
               n.st = flash_seq_pkg::ST_IDLE;
               n.busy = 1'b0;
               n.write_enable_latch = 1'b0;
            end
         end
         flash_seq_pkg::ST_SKIP: begin
            if (cs_stop) begin
               n.st = flash_seq_pkg::ST_IDLE;
            end
         end
         default: n.st = flash_seq_pkg::ST_IDLE;
      endcase
      // Setting the latch wins over the end-of-cycle clear
      if (write_enable_set_i) begin
         n.write_enable_latch = 1'b1;
      end
      if (rd_param_wr_i && four_lane_command_mode_i) begin
         n.wrap[2:1] = rd_param_len_i;
      end
      if (sw_reset_i) begin
         n.wrap = `WRAP_RESET;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         r <= '0;
         r.cs_m <= 1'b1;
         r.cs_s <= 1'b1;
         r.cs_d <= 1'b1;
         r.wrap <= `WRAP_RESET;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffered bytes drain toward the array as clear masks
   sync_fifo #(
      .WIDTH(40),
      .DEPTH(`FIFO_WORDS)
   ) u_wr_fifo (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i({r.page, r.idx[7:0], ~r.pbuf[r.idx[7:0]]}),
      .out_valid_o(mem_valid_o),
      .out_ready_i(mem_ready_i),
      .out_data_o(fifo_out)
   );

   // The array can only pull cells low, so zeros never return to one
   assign mem_addr_o = fifo_out[39:8];
   assign mem_clear_mask_o = fifo_out[7:0];
   assign busy_o = r.busy;
   assign write_enable_latch_o = r.write_enable_latch;
   assign wrap_disable_bit_o = r.wrap[0];
   assign wrap_length_field_o = r.wrap[2:1];
   assign prot_page_o = r.page;

   // Next read address inside the wrap window of any page
   always_comb begin
      wrap_bytes_o = r.wrap[0] ? 7'h00 : 7'(7'h08 << r.wrap[2:1]);
      wmask = 8'(wrap_bytes_o) - 8'h01;
      rd_next_o = rd_addr_i + 32'h1;
      if (!r.wrap[0]) begin
         rd_next_o = {rd_addr_i[31:8], (rd_addr_i[7:0] & ~wmask) | (8'(rd_addr_i[7:0] + 8'h01) & wmask)};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_wrap_capture;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_WRAP && sck_rise && ncnt == `BYTE_BITS && !sw_reset_i && !rd_param_wr_i)
      |=> (r.wrap == $past(shifted[6:4]));
   endproperty
   a_wrap_capture: assert property (p_wrap_capture) else $error("wrap byte not captured");

   property p_wrap_reset;
      @(posedge clk_i) disable iff (!rst_b_i)
      sw_reset_i |=> (wrap_disable_bit_o && wrap_bytes_o == 7'h00);
   endproperty
   a_wrap_reset: assert property (p_wrap_reset) else $error("wrap not disabled after reset");

   property p_wrap8;
      @(posedge clk_i) disable iff (!rst_b_i)
      (!wrap_disable_bit_o && wrap_length_field_o == 2'b00 && rd_addr_i[2:0] == 3'h7)
      |-> (rd_next_o == {rd_addr_i[31:3], 3'h0});
   endproperty
   a_wrap8: assert property (p_wrap8) else $error("8-byte window did not wrap");

   property p_dummy32;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_DUMMY && r.a32 && sck_rise && r.cnt == 6'd23 && !cs_stop)
      |=> (r.st == flash_seq_pkg::ST_DUMMY);
   endproperty
   a_dummy32: assert property (p_dummy32) else $error("dummy phase ended at 24 bits");

   property p_wel_gate;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_OPC && n.st == flash_seq_pkg::ST_ADDR) |-> r.write_enable_latch;
   endproperty
   a_wel_gate: assert property (p_wel_gate) else $error("program taken without latch");

   property p_ptr_wrap;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_DATA && sck_rise && !cs_stop && ncnt == `BYTE_BITS && r.ptr == 8'hff)
      |=> (r.ptr == 8'h00);
   endproperty
   a_ptr_wrap: assert property (p_ptr_wrap) else $error("page pointer left the page");

   property p_partial_byte;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_DATA && cs_stop && (r.cnt != '0 || page_protected_i))
      |=> (!busy_o && r.st == flash_seq_pkg::ST_IDLE);
   endproperty
   a_partial_byte: assert property (p_partial_byte) else $error("bad program not discarded");

   property p_busy_hold;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_PROG && r.tmr == 16'h0000) |-> busy_o [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

   property p_wel_clear;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_PROG && n.st == flash_seq_pkg::ST_IDLE && !write_enable_set_i)
      |=> (!write_enable_latch_o && !busy_o);
   endproperty
   a_wel_clear: assert property (p_wel_clear) else $error("latch kept after program");

   property p_four_byte_variant;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_OPC && sck_rise && !cs_stop && ncnt == `BYTE_BITS && shifted[7:0] == `OP_PP4)
      |=> (four_lane_command_mode_i ? r.st == flash_seq_pkg::ST_SKIP : (r.a32 || r.st == flash_seq_pkg::ST_SKIP));
   endproperty
   a_four_byte_variant: assert property (p_four_byte_variant) else $error("4-byte variant mishandled");

   property p_quad_gate;
      @(posedge clk_i) disable iff (!rst_b_i)
      (r.st == flash_seq_pkg::ST_OPC && n.st == flash_seq_pkg::ST_ADDR && shifted[7:0] == `OP_QPP)
      |-> (quad_io_enable_i && !four_lane_command_mode_i);
   endproperty
   a_quad_gate: assert property (p_quad_gate) else $error("quad program without enable");
endmodule

//--- tb/flash_host.sv
`timescale 1ns/100ps
////////////////////////////////////////
// Host end of the serial link
module flash_host (
   input wire logic clk_i,
   output logic cs_b_o,
   output logic sclk_o,
   output logic [3:0] io_o
);
   // Clock stands low outside frames
   initial begin
      cs_b_o = 1'b1;
      sclk_o = 1'b0;
      io_o = 4'h5;
   end

   // Select falls a few cycles before the first clock rise
   task automatic begin_frame();
      @(posedge clk_i);
      #1;
      cs_b_o = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
   endtask

   // MSB first, w lanes per clock; idle lanes toggle so no stale value helps
   task automatic shift(input logic [31:0] v, input int n, input int w);
      logic [31:0] s;
      s = v << (32 - n);
      for (int i = 0; i < n; i += w) begin
         io_o = (w == 4) ? s[31:28] : {~io_o[3:1], s[31]};
         s = s << w;
         repeat (4) @(posedge clk_i);
         #1;
         sclk_o = 1'b1;
         repeat (4) @(posedge clk_i);
         #1;
         sclk_o = 1'b0;
      end
   endtask

   // Released lanes show the inverse of the last value
   task automatic end_frame();
      repeat (4) @(posedge clk_i);
      #1;
      cs_b_o = 1'b1;
      io_o = ~io_o;
      repeat (4) @(posedge clk_i);
      #1;
   endtask
endmodule

//--- tb/test_serial_flash_wrap_and_page_program.sv
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module test_serial_flash_wrap_and_page_program;
   logic clk_i, rst_b_i, cs_b_i, sclk_i, mem_ready_i, sw_reset_i, rd_param_wr_i, write_enable_set_i;
   logic four_byte_mode_i, four_lane_command_mode_i, quad_io_enable_i, page_protected_i;
   logic [3:0] io_i;
   logic [1:0] rd_param_len_i, wrap_length_field_o;
   logic [31:0] rd_addr_i, rd_next_o, mem_addr_o;
   logic busy_o, write_enable_latch_o, wrap_disable_bit_o, mem_valid_o;
   logic [6:0] wrap_bytes_o;
   logic [23:0] prot_page_o;
   logic [7:0] mem_clear_mask_o, cfg;
   logic [31:0] qa [$];
   logic [7:0] qm [$];
   int err_total = 0, n_compared = 0, seed = 1, m_dis, m_len, write_enable_latch;

   flash_host host (.clk_i(clk_i), .cs_b_o(cs_b_i), .sclk_o(sclk_i), .io_o(io_i));
   flash_seq DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b_i), .sclk_i(sclk_i), .io_i(io_i),
      .four_byte_mode_i(four_byte_mode_i), .four_lane_command_mode_i(four_lane_command_mode_i),
      .quad_io_enable_i(quad_io_enable_i), .write_enable_set_i(write_enable_set_i),
      .sw_reset_i(sw_reset_i), .rd_param_wr_i(rd_param_wr_i), .rd_param_len_i(rd_param_len_i),
      .page_protected_i(page_protected_i), .rd_addr_i(rd_addr_i), .mem_ready_i(mem_ready_i),
      .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
      .wrap_disable_bit_o(wrap_disable_bit_o), .wrap_length_field_o(wrap_length_field_o),
      .wrap_bytes_o(wrap_bytes_o), .rd_next_o(rd_next_o), .prot_page_o(prot_page_o),
      .mem_valid_o(mem_valid_o), .mem_addr_o(mem_addr_o), .mem_clear_mask_o(mem_clear_mask_o));

   ////////////////////////////////////////
   // Clock and a randomly stalling array
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) mem_ready_i <= #1 (($random(seed) & 3) != 0);
   // Collect every accepted array write
   always @(posedge clk_i) begin
      if (rst_b_i && mem_valid_o && mem_ready_i) begin
         qa.push_back(mem_addr_o);
         qm.push_back(mem_clear_mask_o);
      end
   end

   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clk_i);
      #1;
      s = 1'b0;
   endtask

   // Bounded wait; running out ends the run
   task automatic wait_busy(input logic v, input int n);
      int k;
      k = 0;
      while (busy_o !== v && k < n) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      chk(busy_o, v);
      if (busy_o !== v) close_out();
   endtask

   // Model of the stored wrap setting and the next read address
   task automatic chk_wrap();
      logic [31:0] a;
      int w;
      a = $random(seed);
      w = 8 << m_len;
      // Second probe sits on the last byte of its window, where wrapping shows
      for (int j = 0; j < 2; j++) begin
         rd_addr_i = a;
         @(posedge clk_i);
         #1;
         chk(wrap_disable_bit_o, m_dis);
         chk(wrap_length_field_o, m_len);
         chk(wrap_bytes_o, m_dis ? 0 : w);
         chk(rd_next_o, m_dis ? a + 1 : (a & ~(w - 1)) | ((a + 1) & (w - 1)));
         a = a | (w - 1);
      end
   endtask

   // Wrap command; n_w below 8 raises select early
   task automatic wrap_cmd(input logic [7:0] c, input int n_w);
      host.begin_frame();
      host.shift(`OP_SET_WRAP, 8, four_lane_command_mode_i ? 4 : 1);
      host.shift(32'h0, four_byte_mode_i ? 32 : 24, 1);
      host.shift(c, n_w, 1);
      host.end_frame();
   endtask

   // Program frame; the model keeps the page image and predicts the writes
   task automatic prog(input logic [7:0] op, input logic [31:0] a, input int n, input bit part, input bit ok);
      logic [7:0] pg [256];
      bit wr [256];
      int ab, w, o, cnt;
      logic [7:0] d;
      ab = (op == `OP_PP4 || four_byte_mode_i) ? 32 : 24;
      w = four_lane_command_mode_i ? 4 : 1;
      cnt = 0;
      for (int i = 0; i < 256; i++) wr[i] = 0;
      qa.delete();
      qm.delete();
      host.begin_frame();
      host.shift(op, 8, w);
      host.shift(a, ab, w);
      for (int i = 0; i < n; i++) begin
         d = $random(seed);
         o = (a[7:0] + i) % 256;
         pg[o] = d;
         cnt += wr[o] ? 0 : 1;
         wr[o] = 1;
         host.shift(d, 8, (op == `OP_QPP || w == 4) ? 4 : 1);
      end
      if (part) host.shift(32'h1f, 5, 1);
      host.end_frame();
      if (ok) begin
         wait_busy(1'b1, 60);
         chk(prot_page_o, a[31:8]);
         wait_busy(1'b0, 8000);
         write_enable_latch = 0;
         chk(write_enable_latch_o, write_enable_latch);
         chk(qa.size(), cnt);
         if (qa.size() == cnt) begin
            for (int k = 0; k < 256; k++) begin
               if (wr[k]) begin
                  chk(qa.pop_front(), {a[31:8], k[7:0]});
                  chk(qm.pop_front(), {24'h0, ~pg[k]});
               end
            end
         end
      end else begin
         repeat (40) @(posedge clk_i);
         #1;
         chk(busy_o, 1'b0);
         chk(write_enable_latch_o, write_enable_latch);
         chk(qa.size(), 0);
      end
   endtask

   ////////////////////////////////////////
   // Main sequence
   initial begin
      {rst_b_i, sw_reset_i, rd_param_wr_i, write_enable_set_i, four_byte_mode_i} = 5'h0;
      {four_lane_command_mode_i, quad_io_enable_i, page_protected_i} = 3'h0;
      rd_param_len_i = 2'h0;
      rd_addr_i = 32'h0;
      m_dis = 1;
      m_len = 0;
      write_enable_latch = 0;
      repeat (8) @(posedge clk_i);
      #1;
      rst_b_i = 1'b1;
      repeat (3) @(posedge clk_i);
      #1;
      chk(busy_o, 1'b0);
      chk(mem_valid_o, 1'b0);
      chk_wrap();
      // Every length, junk in the unused bits, both address modes
      for (int l = 0; l < 4; l++) begin
         cfg = $random(seed);
         cfg[6:4] = {l[1:0], 1'b0};
         four_byte_mode_i = l[0];
         wrap_cmd(cfg, 8);
         m_dis = 0;
         m_len = l;
         chk_wrap();
      end
      wrap_cmd(8'h9f, 8);
      m_dis = 1;
      m_len = 0;
      chk_wrap();
      wrap_cmd(8'h40, 8);
      m_dis = 0;
      m_len = 2;
      wrap_cmd(8'h70, 5);
      chk_wrap();
      pulse(sw_reset_i);
      m_dis = 1;
      m_len = 0;
      chk_wrap();
      // Read parameters only act in four-lane mode, where the wrap command is refused
      rd_param_len_i = 2'h3;
      pulse(rd_param_wr_i);
      chk_wrap();
      four_lane_command_mode_i = 1'b1;
      pulse(rd_param_wr_i);
      m_len = 3;
      chk_wrap();
      wrap_cmd(8'h00, 8);
      chk_wrap();
      four_lane_command_mode_i = 1'b0;
      four_byte_mode_i = 1'b0;
      // Programs: refused, page crossing, partial byte, protected, long address
      prog(`OP_PP, 32'h0012fc, 2, 0, 0);
      pulse(write_enable_set_i);
      write_enable_latch = 1;
      prog(`OP_PP, 32'h0012fc, 6, 0, 1);
      pulse(write_enable_set_i);
      write_enable_latch = 1;
      prog(`OP_PP, 32'h003400, 2, 1, 0);
      page_protected_i = 1'b1;
      prog(`OP_PP, 32'h005610, 2, 0, 0);
      page_protected_i = 1'b0;
      four_lane_command_mode_i = 1'b1;
      prog(`OP_PP4, 32'h01abcd10, 2, 0, 0);
      four_lane_command_mode_i = 1'b0;
      prog(`OP_PP4, 32'h01abcd10, 3, 0, 1);
      pulse(write_enable_set_i);
      write_enable_latch = 1;
      prog(`OP_QPP, 32'h0077ff, 2, 0, 0);
      quad_io_enable_i = 1'b1;
      prog(`OP_QPP, 32'h0077ff, 258, 0, 1);
      close_out();
   end
endmodule
